// ==== zone_cmd_defs.svh ====
`ifndef ZONE_CMD_DEFS_SVH
`define ZONE_CMD_DEFS_SVH

// command opcodes
`define OPC_LOCK 8'h17
`define OPC_MAC 8'h08

// value written to a lock byte to lock its zone
`define LOCK_VALUE 8'h00

// one-byte status answers
`define STATUS_OK 8'h00
`define STATUS_MISCOMPARE 8'h01
`define STATUS_PARSE 8'h03
`define STATUS_EXEC 8'h0F

// zone sizes in bytes
`define CONFIG_BYTES 10'd88
`define DATA_BYTES 10'd512
`define OTP_BYTES 10'd64
`define DATA_OTP_BYTES 10'd576

// lock zone byte fields
`define ZONE_SEL_BIT 0
`define ZONE_FORCE_BIT 7

// mac mode byte fields
`define MODE_B_TK_BIT 0
`define MODE_A_TK_BIT 1
`define MODE_SRC_BIT 2
`define MODE_RSV3_BIT 3
`define MODE_OTP88_BIT 4
`define MODE_OTP64_BIT 5
`define MODE_SN48_BIT 6
`define MODE_RSV7_BIT 7

// mac message layout, byte positions
`define MSG_B_POS 7'd32
`define MSG_OPC_POS 7'd64
`define MSG_MODE_POS 7'd65
`define MSG_SLOT_LO_POS 7'd66
`define MSG_SLOT_HI_POS 7'd67
`define MSG_OTP_POS 7'd68
`define MSG_OTP_HI_POS 7'd76
`define MSG_SN8_POS 7'd79
`define MSG_SN47_POS 7'd80
`define MSG_SN01_POS 7'd84
`define MSG_SN23_POS 7'd86
`define MSG_LAST_POS 7'd87
`define DIGEST_LAST 6'd31

// crc-16 of the command packets
`define CRC_POLY 16'h8005
`define CRC_INIT 16'h0000

`endif

// ==== zone_cmd_pkg.sv ====
package zone_cmd_pkg;

  typedef enum logic [2:0] {
    RG_CONFIG = 3'h0,
    RG_DATA = 3'h1,
    RG_OTP = 3'h2,
    RG_TEMPKEY = 3'h3,
    RG_CHALLENGE = 3'h4,
    RG_SERIAL = 3'h5
  } mem_region_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CHECK = 4'h1,
    ST_CRC_ADDR = 4'h3,
    ST_CRC_DATA = 4'h2,
    ST_LOCK_CMP = 4'h6,
    ST_LOCK_WRITE = 4'h7,
    ST_RESPOND = 4'h5,
    ST_MSG_ADDR = 4'hC,
    ST_MSG_DATA = 4'hD,
    ST_MSG_PUSH = 4'hF,
    ST_DIGEST = 4'hE
  } state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] param1;
    logic [15:0] param2;
  } cmd_t;

  typedef struct packed {
    logic rd;
    mem_region_t region;
    logic [9:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic from_mem;
    mem_region_t region;
    logic [9:0] addr;
    logic [7:0] value;
  } byte_src_t;

endpackage

// ==== crc16_unit.sv ====
`timescale 1ns/10ps
`include "zone_cmd_defs.svh"

module crc16_unit (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // byte feed
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [7:0] byte_i,
  // running sum
  output logic [15:0] crc_o
);

  // bits enter lsb first, the same way the packet crc is formed
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = d[i] ^ r[15];
      r = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ `CRC_POLY;
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      crc_o <= `CRC_INIT;
    end else if (en_i) begin
      crc_o <= crc_step(crc_o, byte_i);
    end
  end

endmodule

// ==== msg_byte_select.sv ====
`timescale 1ns/10ps
`include "zone_cmd_defs.svh"

module msg_byte_select
  import zone_cmd_pkg::*;
(
  // message position and command
  input wire logic [6:0] idx_i,
  input wire cmd_t cmd_i,
  // where the byte comes from
  output byte_src_t src_o
);

  function automatic logic [9:0] rel(input logic [6:0] i, input logic [6:0] base);
    logic [6:0] d;
    d = i - base;
    return {3'b000, d};
  endfunction

  logic [7:0] mode;
  logic otp_lo_on;
  logic otp_hi_on;
  logic sn_on;

  assign mode = cmd_i.param1;
  assign otp_hi_on = mode[`MODE_OTP88_BIT];
  assign otp_lo_on = mode[`MODE_OTP88_BIT] | mode[`MODE_OTP64_BIT];
  assign sn_on = mode[`MODE_SN48_BIT];

  always_comb begin
    src_o = '{from_mem: 1'b1, region: RG_SERIAL, addr: 10'h000, value: 8'h00};
    if (idx_i < `MSG_B_POS) begin
      src_o.region = mode[`MODE_A_TK_BIT] ? RG_TEMPKEY : RG_DATA;
      src_o.addr = mode[`MODE_A_TK_BIT] ? rel(idx_i, 7'd0)
                                        : {1'b0, cmd_i.param2[3:0], idx_i[4:0]};
    end else if (idx_i < `MSG_OPC_POS) begin
      src_o.region = mode[`MODE_B_TK_BIT] ? RG_TEMPKEY : RG_CHALLENGE;
      src_o.addr = rel(idx_i, `MSG_B_POS);
    end else if (idx_i < `MSG_OTP_POS) begin
      src_o.from_mem = 1'b0;
      case (idx_i)
        `MSG_OPC_POS: src_o.value = cmd_i.opcode;
        `MSG_MODE_POS: src_o.value = mode;
        `MSG_SLOT_LO_POS: src_o.value = cmd_i.param2[7:0];
        default: src_o.value = cmd_i.param2[15:8];
      endcase
    end else if (idx_i < `MSG_OTP_HI_POS) begin
      src_o.from_mem = otp_lo_on;
      src_o.region = RG_OTP;
      src_o.addr = rel(idx_i, `MSG_OTP_POS);
    end else if (idx_i < `MSG_SN8_POS) begin
      src_o.from_mem = otp_hi_on;
      src_o.region = RG_OTP;
      src_o.addr = rel(idx_i, `MSG_OTP_POS);
    end else if (idx_i == `MSG_SN8_POS) begin
      src_o.addr = 10'h008;
    end else if (idx_i < `MSG_SN01_POS) begin
      src_o.from_mem = sn_on;
      src_o.addr = rel(idx_i, 7'd76);
    end else if (idx_i < `MSG_SN23_POS) begin
      src_o.addr = rel(idx_i, `MSG_SN01_POS);
    end else begin
      src_o.from_mem = sn_on;
      src_o.addr = rel(idx_i, 7'd84);
    end
  end

endmodule

// ==== zone_cmd_engine.sv ====
`timescale 1ns/10ps
`include "zone_cmd_defs.svh"

// Summary of operation
// - a successful lock writes 0x00 into the chosen zone's lock byte
// - a lock aimed at an already locked zone fails with an error
// - the zone summary is the packet crc-16 run over the zone bytes
// - the configuration zone summary covers all 88 bytes
// - data and otp summary feeds data zone bytes, then otp bytes
// - a summary mismatch returns an error and leaves the zone unlocked
// - lock opcode 0x17, zone bit 0 picks zone, bits 1-6 must be zero
// - zone bit 7 skips the summary check and locks anyway
// - a successful lock answers with one zero byte
// - mac opcode 0x08 uses slot bits 3:0, hashes all 16 slot bits
// - mac challenge is 32 bytes or absent, unused when mode bit 0 set
// - mac hashes the fixed 88-byte layout and returns a 32-byte digest
// - mode bit 6 includes six serial bytes, otherwise zeros there
// - mode bit 5 alone includes otp 0-7; with neither bit all zeros
// - mode bit 4 includes otp bytes 0-10, bit 5 then ignored
// - with mode bit 0 or 1 set, mode bit 2 must match source flag
// - mode bit 1 picks key slot or temporary digest for bytes 0-31
// - mode bit 0 picks challenge or temporary digest for bytes 32-63
// - a nonce marks the temporary digest valid and records its source
module zone_cmd_engine
  import zone_cmd_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // command
  input wire logic CMD_VALID_I,
  input wire cmd_t CMD_I,
  output logic BUSY_O,
  // lock bytes
  input wire logic CONFIG_LOCKED_I,
  input wire logic DATA_LOCKED_I,
  output logic LOCK_WR_O,
  output logic LOCK_ZONE_O,
  output logic [7:0] LOCK_VALUE_O,
  // temporary digest state
  input wire logic NONCE_DONE_I,
  input wire logic NONCE_PASSTHRU_I,
  output logic TEMPKEY_VALID_O,
  output logic DIGEST_SOURCE_FLAG_O,
  // memory read
  output mem_req_t MEM_REQ_O,
  input wire logic [7:0] MEM_RDATA_I,
  // hash engine
  output logic SHA_VALID_O,
  output logic [7:0] SHA_BYTE_O,
  output logic SHA_LAST_O,
  input wire logic SHA_READY_I,
  input wire logic DIGEST_VALID_I,
  input wire logic [7:0] DIGEST_BYTE_I,
  output logic DIGEST_TAKE_O,
  // response
  output logic RSP_VALID_O,
  output logic [7:0] RSP_BYTE_O,
  output logic RSP_LAST_O,
  input wire logic RSP_READY_I
);
  ////////////////////////////////////////////////////////////////////////////
  state_t state_r;
  cmd_t cmd_r;
  logic [9:0] crc_idx_r;
  logic [6:0] msg_idx_r;
  logic [5:0] dig_cnt_r;
  logic [15:0] crc_val;
  logic [9:0] crc_end;
  logic is_lock;
  logic is_mac;
  logic zone_data;
  logic zone_locked;
  logic rsp_free;
  logic check_fail;
  logic [7:0] check_code;
  state_t check_next;
  byte_src_t src;
  function automatic mem_req_t crc_fetch(input logic [9:0] idx, input logic dz);
    mem_req_t r;
    r = '{rd: 1'b1, region: RG_CONFIG, addr: idx};
    if (dz && idx < `DATA_BYTES) begin
      r.region = RG_DATA;
    end else if (dz) begin
      r.region = RG_OTP;
      r.addr = idx - `DATA_BYTES;
    end
    return r;
  endfunction
  assign is_lock = cmd_r.opcode == `OPC_LOCK;
  assign is_mac = cmd_r.opcode == `OPC_MAC;
  assign zone_data = cmd_r.param1[`ZONE_SEL_BIT];
  assign zone_locked = zone_data ? DATA_LOCKED_I : CONFIG_LOCKED_I;
  assign rsp_free = !RSP_VALID_O || RSP_READY_I;
  assign crc_end = zone_data ? `DATA_OTP_BYTES - 10'd1 : `CONFIG_BYTES - 10'd1;

  ////////////////////////////////////////////////////////////////////////////
  // zone summary and message byte source
  crc16_unit u_crc (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .clr_i(state_r == ST_IDLE),
    .en_i(state_r == ST_CRC_DATA),
    .byte_i(MEM_RDATA_I),
    .crc_o(crc_val)
  );
  msg_byte_select u_sel (
    .idx_i(msg_idx_r),
    .cmd_i(cmd_r),
    .src_o(src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command screening
  always_comb begin
    check_fail = 1'b0;
    check_code = `STATUS_OK;
    check_next = ST_RESPOND;
    if (is_lock) begin
      if (|cmd_r.param1[6:1]) begin
        check_fail = 1'b1;
        check_code = `STATUS_PARSE;
      end else if (zone_locked) begin
        check_fail = 1'b1;
        check_code = `STATUS_EXEC;
      end else if (cmd_r.param1[`ZONE_FORCE_BIT]) begin
        check_next = ST_LOCK_WRITE;
      end else begin
        check_next = ST_CRC_ADDR;
      end
    end else if (is_mac) begin
      if (cmd_r.param1[`MODE_RSV7_BIT] || cmd_r.param1[`MODE_RSV3_BIT]) begin
        check_fail = 1'b1;
        check_code = `STATUS_PARSE;
      end else if ((cmd_r.param1[`MODE_B_TK_BIT] || cmd_r.param1[`MODE_A_TK_BIT]) &&
                   (!TEMPKEY_VALID_O ||
                    cmd_r.param1[`MODE_SRC_BIT] != DIGEST_SOURCE_FLAG_O)) begin
        check_fail = 1'b1;
        check_code = `STATUS_EXEC;
      end else begin
        check_next = ST_MSG_ADDR;
      end
    end else begin
      check_fail = 1'b1;
      check_code = `STATUS_PARSE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // temporary digest validity and source
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      TEMPKEY_VALID_O <= 1'b0;
      DIGEST_SOURCE_FLAG_O <= 1'b0;
    end else if (NONCE_DONE_I) begin
      TEMPKEY_VALID_O <= 1'b1;
      DIGEST_SOURCE_FLAG_O <= NONCE_PASSTHRU_I;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state_r <= ST_IDLE;
      BUSY_O <= 1'b0;
      cmd_r <= '0;
      crc_idx_r <= 10'h000;
      msg_idx_r <= 7'h00;
      dig_cnt_r <= 6'h00;
      MEM_REQ_O <= '{rd: 1'b0, region: RG_CONFIG, addr: 10'h000};
      SHA_VALID_O <= 1'b0;
      SHA_BYTE_O <= 8'h00;
      SHA_LAST_O <= 1'b0;
      DIGEST_TAKE_O <= 1'b0;
      LOCK_WR_O <= 1'b0;
      LOCK_ZONE_O <= 1'b0;
      LOCK_VALUE_O <= `LOCK_VALUE;
      RSP_VALID_O <= 1'b0;
      RSP_BYTE_O <= 8'h00;
      RSP_LAST_O <= 1'b0;
    end else begin
      MEM_REQ_O.rd <= 1'b0;
      LOCK_WR_O <= 1'b0;
      DIGEST_TAKE_O <= 1'b0;
      if (RSP_VALID_O && RSP_READY_I) begin
        RSP_VALID_O <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          if (CMD_VALID_I) begin
            cmd_r <= CMD_I;
            BUSY_O <= 1'b1;
            state_r <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          crc_idx_r <= 10'h000;
          msg_idx_r <= 7'h00;
          if (check_fail) begin
            RSP_VALID_O <= 1'b1;
            RSP_BYTE_O <= check_code;
            RSP_LAST_O <= 1'b1;
          end
          state_r <= check_next;
        end
        ST_CRC_ADDR: begin
          MEM_REQ_O <= crc_fetch(crc_idx_r, zone_data);
          state_r <= ST_CRC_DATA;
        end
        ST_CRC_DATA: begin
          if (crc_idx_r == crc_end) begin
            state_r <= ST_LOCK_CMP;
          end else begin
            crc_idx_r <= crc_idx_r + 10'd1;
            state_r <= ST_CRC_ADDR;
          end
        end
        ST_LOCK_CMP: begin
          if (crc_val == cmd_r.param2) begin
            state_r <= ST_LOCK_WRITE;
          end else begin
            RSP_VALID_O <= 1'b1;
            RSP_BYTE_O <= `STATUS_MISCOMPARE;
            RSP_LAST_O <= 1'b1;
            state_r <= ST_RESPOND;
          end
        end
        ST_LOCK_WRITE: begin
          LOCK_WR_O <= 1'b1;
          LOCK_ZONE_O <= zone_data;
          LOCK_VALUE_O <= `LOCK_VALUE;
          RSP_VALID_O <= 1'b1;
          RSP_BYTE_O <= `STATUS_OK;
          RSP_LAST_O <= 1'b1;
          state_r <= ST_RESPOND;
        end
        ST_MSG_ADDR: begin
          SHA_LAST_O <= msg_idx_r == `MSG_LAST_POS;
          if (src.from_mem) begin
            MEM_REQ_O <= '{rd: 1'b1, region: src.region, addr: src.addr};
            state_r <= ST_MSG_DATA;
          end else begin
            SHA_VALID_O <= 1'b1;
            SHA_BYTE_O <= src.value;
            state_r <= ST_MSG_PUSH;
          end
        end
        ST_MSG_DATA: begin
          SHA_VALID_O <= 1'b1;
          SHA_BYTE_O <= MEM_RDATA_I;
          state_r <= ST_MSG_PUSH;
        end
        ST_MSG_PUSH: begin
          if (SHA_READY_I) begin
            SHA_VALID_O <= 1'b0;
            dig_cnt_r <= 6'h00;
            msg_idx_r <= msg_idx_r + 7'd1;
            state_r <= SHA_LAST_O ? ST_DIGEST : ST_MSG_ADDR;
          end
        end
        ST_DIGEST: begin
          if (DIGEST_VALID_I && !DIGEST_TAKE_O && rsp_free) begin
            DIGEST_TAKE_O <= 1'b1;
            RSP_VALID_O <= 1'b1;
            RSP_BYTE_O <= DIGEST_BYTE_I;
            RSP_LAST_O <= dig_cnt_r == `DIGEST_LAST;
            dig_cnt_r <= dig_cnt_r + 6'd1;
            if (dig_cnt_r == `DIGEST_LAST) begin
              state_r <= ST_RESPOND;
            end
          end
        end
        ST_RESPOND: begin
          if (RSP_VALID_O && RSP_READY_I && RSP_LAST_O) begin
            state_r <= ST_IDLE;
            BUSY_O <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);
  a_lock_writes_zero: assert property (
    LOCK_WR_O |-> LOCK_VALUE_O == 8'h00 && LOCK_ZONE_O == cmd_r.param1[0])
    else $error("lock byte written with a nonzero value or wrong zone");
  a_locked_zone_refused: assert property (
    state_r == ST_CHECK && is_lock && zone_locked
    |=> state_r == ST_RESPOND && RSP_VALID_O && RSP_BYTE_O != 8'h00 && !LOCK_WR_O)
    else $error("lock of a locked zone did not fail");
  a_crc_feed_bytes: assert property (
    state_r == ST_CRC_DATA |-> MEM_REQ_O.rd && crc_idx_r <= crc_end)
    else $error("summary fed without a fresh memory byte");
  a_config_crc_span: assert property (
    state_r == ST_CRC_DATA && !zone_data |-> MEM_REQ_O.region == RG_CONFIG && crc_idx_r < 10'd88)
    else $error("configuration summary left its 88 bytes");
  a_data_then_otp: assert property (
    MEM_REQ_O.rd && is_lock && MEM_REQ_O.region == RG_OTP
    |-> crc_idx_r == MEM_REQ_O.addr + 10'd512)
    else $error("otp bytes fed before the data zone finished");
  a_mismatch_no_lock: assert property (
    state_r == ST_LOCK_CMP && crc_val != cmd_r.param2
    |=> RSP_BYTE_O == 8'h01 && !LOCK_WR_O ##1 !LOCK_WR_O)
    else $error("mismatched summary still locked the zone");
  a_zone_bits_parse: assert property (
    state_r == ST_CHECK && is_lock && |cmd_r.param1[6:1]
    |=> RSP_VALID_O && RSP_BYTE_O == 8'h03)
    else $error("lock with reserved zone bits accepted");
  a_forced_lock: assert property (
    state_r == ST_CHECK && is_lock && cmd_r.param1[7] && !check_fail
    |=> LOCK_WR_O == 1'b0 ##1 LOCK_WR_O)
    else $error("forced lock did not lock in two cycles");
  a_lock_success_byte: assert property (
    $rose(LOCK_WR_O) |-> RSP_VALID_O && RSP_BYTE_O == 8'h00 && RSP_LAST_O)
    else $error("successful lock did not answer a single zero byte");
  a_slot_bytes: assert property (
    SHA_VALID_O && msg_idx_r == 7'd66 |-> SHA_BYTE_O == cmd_r.param2[7:0])
    else $error("slot parameter low byte missing from message");
  a_key_slot_addr: assert property (
    MEM_REQ_O.rd && is_mac && msg_idx_r < 7'd32
    |-> MEM_REQ_O.region == (cmd_r.param1[1] ? RG_TEMPKEY : RG_DATA) &&
        (cmd_r.param1[1] || MEM_REQ_O.addr[8:5] == cmd_r.param2[3:0]))
    else $error("first message half taken from the wrong place");
  a_challenge_src: assert property (
    MEM_REQ_O.rd && is_mac && msg_idx_r >= 7'd32 && msg_idx_r < 7'd64
    |-> MEM_REQ_O.region == (cmd_r.param1[0] ? RG_TEMPKEY : RG_CHALLENGE))
    else $error("second message half taken from the wrong place");
  a_opcode_byte: assert property (
    SHA_VALID_O && msg_idx_r == 7'd64 |-> SHA_BYTE_O == 8'h08 && !SHA_LAST_O)
    else $error("opcode byte wrong in message");
  a_serial_zeroed: assert property (
    SHA_VALID_O && !cmd_r.param1[6] &&
    ((msg_idx_r >= 7'd80 && msg_idx_r < 7'd84) || msg_idx_r >= 7'd86)
    |-> SHA_BYTE_O == 8'h00)
    else $error("hidden serial bytes reached the message");
  a_otp_zeroed: assert property (
    SHA_VALID_O && !cmd_r.param1[4] && msg_idx_r >= 7'd68 && msg_idx_r < 7'd79 &&
    (!cmd_r.param1[5] || msg_idx_r >= 7'd76)
    |-> SHA_BYTE_O == 8'h00)
    else $error("hidden otp bytes reached the message");
  a_otp_full: assert property (
    state_r == ST_MSG_ADDR && cmd_r.param1[4] && msg_idx_r >= 7'd68 && msg_idx_r < 7'd79
    |=> MEM_REQ_O.rd && MEM_REQ_O.region == RG_OTP)
    else $error("otp byte not fetched with mode bit 4 set");
  a_source_mismatch: assert property (
    state_r == ST_CHECK && is_mac && !cmd_r.param1[7] && !cmd_r.param1[3] &&
    |cmd_r.param1[1:0] && cmd_r.param1[2] != DIGEST_SOURCE_FLAG_O
    |=> RSP_BYTE_O == 8'h0F ##1 !SHA_VALID_O)
    else $error("source flag mismatch not refused");
  a_nonce_marks: assert property (
    NONCE_DONE_I |=> TEMPKEY_VALID_O && DIGEST_SOURCE_FLAG_O == $past(NONCE_PASSTHRU_I))
    else $error("nonce did not mark the temporary digest");
  a_reserved_mode: assert property (
    state_r == ST_CHECK && is_mac && (cmd_r.param1[7] || cmd_r.param1[3])
    |=> RSP_BYTE_O == 8'h03 && state_r == ST_RESPOND)
    else $error("mac with reserved mode bits accepted");
  c_lock_done: cover property (LOCK_WR_O && !cmd_r.param1[7]);
  c_lock_miscompare: cover property (state_r == ST_LOCK_CMP && crc_val != cmd_r.param2);
  c_mac_digest: cover property (DIGEST_TAKE_O && RSP_LAST_O);
  c_mac_serial: cover property (SHA_VALID_O && cmd_r.param1[6] && msg_idx_r == 7'd87);

endmodule

// ==== env_model.sv ====
`timescale 1ns/10ps
module env_model
  import zone_cmd_pkg::*;
(
  // clock, reset and pacing
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  // memory read
  input wire mem_req_t req_i,
  output logic [7:0] rdata_o,
  // hash engine
  input wire logic sha_valid_i,
  input wire logic [7:0] sha_byte_i,
  input wire logic sha_last_i,
  output logic sha_ready_o,
  output logic digest_valid_o,
  output logic [7:0] digest_byte_o,
  input wire logic digest_take_i
);
  logic [7:0] msg [0:87];
  logic [7:0] img;
  int n_msg;
  int got_len;
  int n_dig;
  assign img = req_i.addr[7:0] ^ {req_i.region, req_i.addr[9:8], 3'h5};
  // outside the read strobe the bus shows the inverse, so stale data cannot pass
  assign rdata_o = req_i.rd ? img : ~img;
  assign sha_ready_o = !stall_i;
  assign digest_valid_o = n_dig < 32;
  assign digest_byte_o = digest_valid_o ? 8'hC0 + 8'(n_dig) : 8'h5A ^ 8'(n_dig);
  always @(posedge clk_i) begin
    if (rst_i) begin
      n_msg <= 0;
      n_dig <= 32;
      got_len <= 0;
    end else begin
      if (sha_valid_i && sha_ready_o) begin
        if (n_msg < 88) msg[n_msg] <= sha_byte_i;
        n_msg <= sha_last_i ? 0 : n_msg + 1;
        if (sha_last_i) begin
          got_len <= n_msg + 1;
          n_dig <= 0;
        end
      end
      if (digest_take_i && digest_valid_o) n_dig <= n_dig + 1;
    end
  end
endmodule

// ==== testbench.sv ====
`timescale 1ns/10ps
`include "zone_cmd_defs.svh"
module testbench
  import zone_cmd_pkg::*;
;
  logic clk, rst, cmd_valid, busy, cfg_lk, dat_lk, lock_wr, lock_zone;
  logic nonce_done, nonce_pt, tk_valid, src_flag, sha_valid, sha_last, sha_ready;
  logic dig_valid, dig_take, rsp_valid, rsp_last, rsp_ready, stall;
  logic [7:0] lock_val, mem_rdata, sha_byte, dig_byte, rsp_byte, m;
  logic [15:0] crc_cfg, crc_dat;
  cmd_t cmd;
  mem_req_t mem_req;
  logic [7:0] rsp_q [$];
  int error_cnt, n_checks, n_wr, seed;
  logic wr_zone;
  logic [7:0] mode_list [6] = '{8'h00, 8'h20, 8'h30, 8'h41, 8'h52, 8'h73};

  zone_cmd_engine u_dut (.SYS_CLK_I(clk), .RST_I(rst), .CMD_VALID_I(cmd_valid),
    .CMD_I(cmd), .BUSY_O(busy), .CONFIG_LOCKED_I(cfg_lk), .DATA_LOCKED_I(dat_lk),
    .LOCK_WR_O(lock_wr), .LOCK_ZONE_O(lock_zone), .LOCK_VALUE_O(lock_val),
    .NONCE_DONE_I(nonce_done), .NONCE_PASSTHRU_I(nonce_pt), .TEMPKEY_VALID_O(tk_valid),
    .DIGEST_SOURCE_FLAG_O(src_flag), .MEM_REQ_O(mem_req), .MEM_RDATA_I(mem_rdata),
    .SHA_VALID_O(sha_valid), .SHA_BYTE_O(sha_byte), .SHA_LAST_O(sha_last),
    .SHA_READY_I(sha_ready), .DIGEST_VALID_I(dig_valid), .DIGEST_BYTE_I(dig_byte),
    .DIGEST_TAKE_O(dig_take), .RSP_VALID_O(rsp_valid), .RSP_BYTE_O(rsp_byte),
    .RSP_LAST_O(rsp_last), .RSP_READY_I(rsp_ready));
  env_model u_model (.clk_i(clk), .rst_i(rst), .stall_i(stall), .req_i(mem_req),
    .rdata_o(mem_rdata), .sha_valid_i(sha_valid), .sha_byte_i(sha_byte),
    .sha_last_i(sha_last), .sha_ready_o(sha_ready), .digest_valid_o(dig_valid),
    .digest_byte_o(dig_byte), .digest_take_i(dig_take));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] pat(input int r, input int a);
    return 8'(a) ^ {3'(r), 2'(a >> 8), 3'h5};
  endfunction

  function automatic logic [15:0] crc(input logic [15:0] c, input int r, input int n);
    logic [7:0] d;
    for (int a = 0; a < n; a++) begin
      d = pat(r, a);
      for (int b = 0; b < 8; b++) c = {c[14:0], 1'b0} ^ ((d[b] ^ c[15]) ? 16'h8005 : 16'h0);
    end
    return c;
  endfunction

  // expected hash message byte i for mode mm and slot word s
  function automatic logic [7:0] ex(input logic [7:0] mm, input logic [15:0] s, input int i);
    if (i < 32) return mm[1] ? pat(3, i) : pat(1, s[3:0] * 32 + i);
    if (i < 64) return mm[0] ? pat(3, i - 32) : pat(4, i - 32);
    case (i)
      64: return `OPC_MAC;
      65: return mm;
      66: return s[7:0];
      67: return s[15:8];
      79: return pat(5, 8);
      84, 85: return pat(5, i - 84);
      default: ;
    endcase
    if (i < 76) return (mm[4] | mm[5]) ? pat(2, i - 68) : 8'h00;
    if (i < 79) return mm[4] ? pat(2, i - 68) : 8'h00;
    if (i < 84) return mm[6] ? pat(5, i - 76) : 8'h00;
    return mm[6] ? pat(5, i - 84) : 8'h00;
  endfunction

  always @(posedge clk) begin
    if (lock_wr === 1'b1) begin
      n_wr++;
      wr_zone = lock_zone;
      chk(lock_val, `LOCK_VALUE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic run(input cmd_t c);
    int k;
    rsp_q = {};
    n_wr = 0;
    k = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = c;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk(busy, 1'b1);
    do begin
      @(negedge clk);
      rsp_ready = 1'($random(seed));
      stall = 1'($random(seed));
      @(posedge clk);
      if (rsp_valid === 1'b1 && rsp_ready) rsp_q.push_back(rsp_byte);
      k++;
    end while (!(rsp_valid === 1'b1 && rsp_ready && rsp_last === 1'b1) && k < 5000);
    @(negedge clk);
    chk(busy, 1'b0);
  endtask

  task automatic lock(input logic [7:0] z, input logic [15:0] s, input logic [7:0] st);
    run({`OPC_LOCK, z, s});
    chk(16'(rsp_q.size()), 16'd1);
    chk(rsp_q[0], st);
    chk(16'(n_wr), 16'(st == `STATUS_OK));
    if (st == `STATUS_OK) chk(wr_zone, z[0]);
  endtask

  task automatic mac(input logic [7:0] mm, input logic [15:0] s, input logic [7:0] st);
    run({`OPC_MAC, mm, s});
    if (st != `STATUS_OK) chk(rsp_q[0], st);
    else begin
      chk(16'(u_model.got_len), 16'd88);
      for (int i = 0; i < 88; i++) chk(u_model.msg[i], ex(mm, s, i));
      for (int i = 0; i < 32; i++) chk(rsp_q[i], 8'hC0 + 8'(i));
    end
  endtask

  task automatic nonce(input logic pt);
    @(negedge clk);
    nonce_done = 1'b1;
    nonce_pt = pt;
    @(negedge clk);
    nonce_done = 1'b0;
    @(negedge clk);
    chk(tk_valid, 1'b1);
    chk(src_flag, pt);
  endtask

  initial begin
    #(100 * 60000);
    error_cnt++;
    summarize;
  end

  initial begin
    {rst, seed} = {1'b1, 32'd17};
    {cmd_valid, cfg_lk, dat_lk, nonce_done, nonce_pt, rsp_ready, stall} = '0;
    cmd = '0;
    crc_cfg = crc(`CRC_INIT, 0, 88);
    crc_dat = crc(crc(`CRC_INIT, 1, 512), 2, 64);
    repeat (20) @(negedge clk);
    rst = 1'b0;
    lock(8'h02, 16'h0000, `STATUS_PARSE);
    mac(8'h01, 16'h0000, `STATUS_EXEC);
    lock(8'h80, 16'h0000, `STATUS_OK);
    lock(8'h00, crc_cfg, `STATUS_OK);
    lock(8'h00, crc_cfg ^ 16'h0001, `STATUS_MISCOMPARE);
    lock(8'h01, crc_dat, `STATUS_OK);
    lock(8'h01, crc_dat ^ 16'h8000, `STATUS_MISCOMPARE);
    cfg_lk = 1'b1;
    lock(8'h00, crc_cfg, `STATUS_EXEC);
    {cfg_lk, dat_lk} = 2'b01;
    lock(8'h81, 16'h0000, `STATUS_EXEC);
    dat_lk = 1'b0;
    nonce(1'b1);
    nonce(1'b0);
    mac(8'h80, 16'h0000, `STATUS_PARSE);
    mac(8'h08, 16'h0000, `STATUS_PARSE);
    mac(8'h07, 16'h0000, `STATUS_EXEC);
    foreach (mode_list[j]) begin
      mac(mode_list[j], 16'hFFFF, `STATUS_OK);
    end
    repeat (10) begin
      m = 8'($random(seed)) & 8'h73;
      mac(m, 16'($random(seed)), `STATUS_OK);
    end
    nonce(1'b1);
    mac(8'h06, 16'h0003, `STATUS_OK);
    run({8'h16, 8'h00, 16'h0000});
    chk(rsp_q[0], `STATUS_PARSE);
    summarize;
  end
endmodule
